// >>> common/ivfm_cfg.svh
// Purpose: Constants for the input-voltage fault monitor: command codes,
//          field positions, reset values, status bits and timing.
// Assumes: Thresholds use the 16-bit linear format (5-bit exp, 11-bit mantissa).
// Notes:   Definitions only.
`ifndef IVFM_CFG_SVH
`define IVFM_CFG_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define IVFM_CMD_CLEAR_FAULTS  8'h03
`define IVFM_CMD_OV_RESP       8'h56
`define IVFM_CMD_OV_WARN       8'h57
`define IVFM_CMD_UV_WARN       8'h58
`define IVFM_CMD_STATUS_WORD   8'h79
`define IVFM_CMD_STATUS_INPUT  8'h7C

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define IVFM_OV_RESP_RST       8'h80
`define IVFM_OV_WARN_RST       16'hD3E0
`define IVFM_UV_WARN_RST       16'hCB80
`define IVFM_MODE_HI           7
`define IVFM_MODE_LO           6
`define IVFM_RETRY_HI          5
`define IVFM_RETRY_LO          3
`define IVFM_DELAY_HI          2
`define IVFM_DELAY_LO          0
`define IVFM_MODE_RETRY        2'h2
`define IVFM_EXP_HI            15
`define IVFM_EXP_LO            11
`define IVFM_MAN_HI            10

// ----------------------------------------------------------------------------
// Status bits and threshold spans
// ----------------------------------------------------------------------------
`define IVFM_SW_INPUT          13
`define IVFM_SW_NOTA           0
`define IVFM_SI_OV_FAULT       7
`define IVFM_SI_OV_WARN        6
`define IVFM_SI_UV_WARN        5
`define IVFM_SI_UV_FAULT       4
`define IVFM_FRAC_BITS         8
`define IVFM_OV_WARN_MAX_V     18
`define IVFM_UV_WARN_MAX_V     16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IVFM_CLK_MHZ           50
`define IVFM_RETRY_UNIT_US     35000
`define IVFM_RETRY_UNIT_CYC    (`IVFM_RETRY_UNIT_US * `IVFM_CLK_MHZ)
`define IVFM_UNIT_W            32

`endif

// >>> common/ivfm_pkg.sv
// Purpose: Types shared by the input-voltage fault monitor.
// Assumes: ivfm_cfg.svh is on the include path.
// Notes:   The whole register state is one packed struct.
`default_nettype none
`include "ivfm_cfg.svh"

package ivfm_pkg;

	// ------------------------------------------------------------------------
	// Power stage sequencing states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		IVFM_ST_OFF,
		IVFM_ST_RUN,
		IVFM_ST_LATCH,
		IVFM_ST_RETRY
	} ivfm_state_t;

	// ------------------------------------------------------------------------
	// Complete state of the monitor
	// ------------------------------------------------------------------------
	typedef struct packed {
		ivfm_state_t              st;
		logic [7:0]               ov_resp;
		logic [15:0]              ov_warn;
		logic [15:0]              uv_warn;
		logic [7:0]               stat_in;
		logic                     sw_nota;
		logic                     sw_input;
		logic                     uv_hold;
		logic [`IVFM_UNIT_W-1:0]  unit_cnt;
		logic [2:0]               slot;
		logic                     tmr_done;
		logic [15:0]              rdata;
		logic                     done;
		logic                     reject;
		logic                     pwr;
		logic                     alert_n;
	} ivfm_regs_t;

endpackage
`default_nettype wire

// >>> dv/ivfm_host_model.sv
// Purpose: Host controller model driving the framed command port.
// Assumes: One command per call; the answer stands in the cycle after the take.
// Notes:   Released lines carry the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none

module ivfm_host_model (
	input  wire logic        mclk_in,
	output logic             cmd_valid_out,
	output logic             cmd_write_out,
	output logic [7:0]       cmd_code_out,
	output logic [15:0]      cmd_wdata_out,
	input  wire logic [15:0] cmd_rdata_in,
	input  wire logic        cmd_done_in,
	input  wire logic        cmd_reject_in
);
	import ivfm_pkg::*;

	// Idle port at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_wdata_out = 16'h0000;
	end

	// One transfer: request held up to the take edge, answer read after it
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
		output logic [15:0] rdata, output logic rej, output logic ok);
		@(posedge mclk_in);
		#1;
		cmd_valid_out = 1'b1;
		cmd_write_out = wr;
		cmd_code_out = code;
		cmd_wdata_out = data;
		@(posedge mclk_in);
		#1;
		cmd_valid_out = 1'b0;
		// Stale values must never look valid to the block
		cmd_write_out = ~wr;
		cmd_code_out = ~code;
		cmd_wdata_out = ~data;
		ok = (cmd_done_in === 1'b1);
		rdata = cmd_rdata_in;
		rej = cmd_reject_in;
	endtask
endmodule
`default_nettype wire

// >>> dv/test_input_voltage_fault_monitor.sv
// Purpose: Self-checking bench for the input-voltage fault monitor.
// Assumes: Retry unit shortened to 20 cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
`include "ivfm_cfg.svh"

module test_input_voltage_fault_monitor;
	import ivfm_pkg::*;
	localparam int UNIT = 20;
	logic        mclk_in, nrst_in, cmd_valid, cmd_write, cmd_done, cmd_reject;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, vin;
	logic        ov_f, uv_f, uv_rt, en, oth, pwr, alert_n, alert_oe_n;
	int          error_cnt, tests_run, k;
	logic [7:0]  codes [4] = '{8'h80, 8'h09, 8'h49, 8'hC9};

	ivfm_top #(.RETRY_UNIT_CYC(UNIT)) uut (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write), .cmd_code_in(cmd_code),
		.cmd_wdata_in(cmd_wdata), .cmd_rdata_out(cmd_rdata), .cmd_done_out(cmd_done),
		.cmd_reject_out(cmd_reject), .vin_meas_in(vin), .vin_ov_fault_in(ov_f),
		.vin_uv_fault_in(uv_f), .uv_retry_in(uv_rt), .enable_in(en),
		.other_fault_in(oth), .power_enable_out(pwr), .alert_output_n_out(alert_n),
		.alert_oe_n_out(alert_oe_n));
	ivfm_host_model host (.mclk_in(mclk_in), .cmd_valid_out(cmd_valid),
		.cmd_write_out(cmd_write), .cmd_code_out(cmd_code), .cmd_wdata_out(cmd_wdata),
		.cmd_rdata_in(cmd_rdata), .cmd_done_in(cmd_done), .cmd_reject_in(cmd_reject));

	// Free-running 50 MHz clock
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end

	task automatic results();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick();
		@(posedge mclk_in);
		#1;
	endtask

	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic [15:0] exp, input logic exp_rej);
		logic [15:0] rd;
		logic        rj, ok;
		host.xfer(w, c, d, rd, rj, ok);
		chk("done", 16'h0001, {15'h0, ok});
		chk("reject", {15'h0, exp_rej}, {15'h0, rj});
		if (!w && c != `IVFM_CMD_CLEAR_FAULTS) chk("read data", exp, rd);
	endtask

	// Output must stay off every cycle of the span
	task automatic hold_off(input int n);
		logic on;
		on = 1'b0;
		repeat (n) begin
			tick();
			if (pwr !== 1'b0) on = 1'b1;
		end
		chk("output held off", 16'h0000, {15'h0, on});
	endtask

	// Restart must land inside the window; a hang ends the run
	task automatic wait_pwr(input int lo, input int hi);
		int n;
		n = 0;
		while (pwr !== 1'b1 && n <= hi) begin
			tick();
			n++;
		end
		chk("restart in window", 16'h0001, {15'h0, n >= lo && n <= hi});
		if (n > hi) results();
	endtask

	task automatic pulse_ov();
		ov_f = 1'b1;
		tick();
		ov_f = 1'b0;
	endtask

	initial begin
		error_cnt = 0;
		tests_run = 0;
		{nrst_in, ov_f, uv_f, uv_rt, oth} = 5'h00;
		en = 1'b1;
		vin = 16'h0C00; // 12 V
		repeat (5) @(posedge mclk_in);
		#1;
		nrst_in = 1'b1;
		wait_pwr(1, 4);
		// Reset values and refusals
		cmd(0, 8'h56, 0, 16'h0080, 0);
		cmd(0, 8'h57, 0, 16'hD3E0, 0);
		cmd(0, 8'h58, 0, 16'hCB80, 0);
		cmd(0, 8'h7C, 0, 16'h0000, 0);
		cmd(0, 8'h2A, 0, 16'h0000, 1);
		cmd(1, 8'h79, 0, 0, 1);
		// Span limits at both signs of exponent and mantissa
		cmd(1, 8'h57, 16'hDA40, 0, 0);
		cmd(1, 8'h57, 16'hDA41, 0, 1);
		cmd(1, 8'h57, 16'hDFFF, 0, 1);
		cmd(1, 8'h57, 16'h080A, 0, 1);
		cmd(1, 8'h57, 16'h0809, 0, 0);
		cmd(1, 8'h58, 16'hDA01, 0, 1);
		cmd(1, 8'h58, 16'hDA00, 0, 0);
		cmd(0, 8'h57, 0, 16'h0809, 0);
		cmd(0, 8'h58, 0, 16'hDA00, 0);
		// Defaults back; host keeps warnings inside the fault limits
		cmd(1, 8'h57, 16'hD3E0, 0, 0);
		cmd(1, 8'h58, 16'hCB80, 0, 0);
		// A 16 V undervoltage warning sat above the 12 V input meanwhile
		cmd(0, 8'h7C, 0, 16'h0020, 0);
		cmd(1, 8'h03, 0, 0, 0);
		// Overvoltage warning is sticky until cleared
		vin = 16'h1000;
		repeat (2) tick();
		cmd(0, 8'h7C, 0, 16'h0040, 0);
		cmd(0, 8'h79, 0, 16'h2001, 0);
		chk("alert", 16'h0000, {15'h0, alert_n});
		vin = 16'h0C00;
		tick();
		cmd(0, 8'h7C, 0, 16'h0040, 0);
		cmd(1, 8'h03, 0, 0, 0);
		cmd(0, 8'h7C, 0, 16'h0000, 0);
		chk("alert", 16'h0001, {15'h0, alert_n});
		// Undervoltage warning
		vin = 16'h0500;
		repeat (2) tick();
		cmd(0, 8'h7C, 0, 16'h0020, 0);
		cmd(0, 8'h79, 0, 16'h2001, 0);
		chk("alert", 16'h0000, {15'h0, alert_n});
		vin = 16'h0C00;
		cmd(1, 8'h03, 0, 0, 0);
		// Non-retry codes latch off until cleared
		for (k = 0; k < 4; k++) begin
			cmd(1, 8'h56, {8'h00, codes[k]}, 0, 0);
			pulse_ov();
			chk("output off", 16'h0000, {15'h0, pwr});
			chk("alert", 16'h0000, {15'h0, alert_n});
			chk("alert drive", 16'h0000, {15'h0, alert_oe_n});
			hold_off(3 * UNIT);
			cmd(0, 8'h7C, 0, 16'h0080, 0);
			cmd(1, 8'h03, 0, 0, 0);
			wait_pwr(1, 4);
		end
		// Retry interval at both ends of the delay field, repeated faults
		for (k = 0; k < 8; k += 7) begin
			cmd(1, 8'h56, 16'(16'h0088 | k), 0, 0);
			pulse_ov();
			wait_pwr((k + 1) * UNIT - 1, (k + 1) * UNIT + 4);
		end
		// Restart waits for input below the warning level
		cmd(1, 8'h56, 16'h0089, 0, 0);
		vin = 16'h1000;
		pulse_ov();
		hold_off(3 * UNIT);
		vin = 16'h0C00;
		wait_pwr(1, 4);
		// Commanded off or other fault stops retrying
		for (k = 0; k < 2; k++) begin
			pulse_ov();
			if (k == 0) en = 1'b0;
			else oth = 1'b1;
			hold_off(3 * UNIT);
			en = 1'b1;
			oth = 1'b0;
			wait_pwr(1, 2 * UNIT + 6);
		end
		// Undervoltage retry waits for input above its warning
		uv_rt = 1'b1;
		vin = 16'h0500;
		uv_f = 1'b1;
		tick();
		uv_f = 1'b0;
		tick();
		hold_off(UNIT);
		vin = 16'h0C00;
		wait_pwr(1, 4);
		// All four input status bits (7:4) are still standing: none was cleared since
		cmd(0, 8'h7C, 0, 16'h00F0, 0);
		results();
	end
endmodule
`default_nettype wire

// >>> src/ivfm_lin_dec.sv
// Purpose: Decode a 16-bit linear word into fixed-point volts and check span.
// Assumes: Exponent in bits 15:11, mantissa in 10:0, both two's complement.
// Notes:   Result carries FRAC_BITS fraction bits; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "ivfm_cfg.svh"

module ivfm_lin_dec #(
	parameter int MAX_V = 18
) (
	input  wire logic [15:0]        word_in,
	output logic signed [39:0]      value_out,
	output logic                    in_range_out
);
	import ivfm_pkg::*;

	localparam logic signed [39:0] MAX_FX = 40'(MAX_V) <<< `IVFM_FRAC_BITS;

	// ------------------------------------------------------------------------
	// Mantissa times two to the exponent
	// ------------------------------------------------------------------------
	always_comb begin
		int sh;
		logic signed [39:0] man;
		sh = int'($signed(word_in[`IVFM_EXP_HI:`IVFM_EXP_LO])) + `IVFM_FRAC_BITS;
		man = 40'($signed(word_in[`IVFM_MAN_HI:0]));
		// Small exponents lose fraction bits below 1/256 V, well under a count
		if (sh >= 0) begin
			value_out = man <<< sh;
		end else begin
			value_out = man >>> (-sh);
		end
		in_range_out = (value_out >= 40'sh0) && (value_out <= MAX_FX);
	end

endmodule
`default_nettype wire

// >>> src/ivfm_top.sv
// What this block does
// - Response code 10 means disable and retry
// - Fault drives alert low, sets status bit
// - Fault bits clear only on clear-faults command
// - Retry setting 000 keeps output off latched
// - Other retry settings restart until commanded off
// - Restart waits for input below overvoltage warning
// - Restart interval is (delay+1) times 35 ms
// - Overvoltage warning sets status bits, alerts host
// - Undervoltage warning sets status bits, alerts host
// - Out-of-span threshold writes are refused
// - Undervoltage retry waits for input above warning
//
// Purpose: Input-voltage warning and overvoltage fault response logic.
// Assumes: Measured input is unsigned volts with 8 fraction bits; the fault
//          comparators live elsewhere and arrive as levels.
// Notes:   Commands arrive already framed by the serial bus engine.
`timescale 1ns/100ps
`default_nettype none
`include "ivfm_cfg.svh"

module ivfm_top #(
	parameter int unsigned RETRY_UNIT_CYC = `IVFM_RETRY_UNIT_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        nrst_in,
	input  wire logic        cmd_valid_in,
	input  wire logic        cmd_write_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic [15:0] cmd_wdata_in,
	output logic [15:0]      cmd_rdata_out,
	output logic             cmd_done_out,
	output logic             cmd_reject_out,
	input  wire logic [15:0] vin_meas_in,
	input  wire logic        vin_ov_fault_in,
	input  wire logic        vin_uv_fault_in,
	input  wire logic        uv_retry_in,
	input  wire logic        enable_in,
	input  wire logic        other_fault_in,
	output logic             power_enable_out,
	output logic             alert_output_n_out,
	output logic             alert_oe_n_out
);
	import ivfm_pkg::*;

	localparam logic [`IVFM_UNIT_W-1:0] UNIT_LAST = `IVFM_UNIT_W'(RETRY_UNIT_CYC - 1);

	ivfm_regs_t         r_q;
	ivfm_regs_t         r_d;
	logic signed [39:0] wr_val_ov;
	logic signed [39:0] wr_val_uv;
	logic signed [39:0] ov_thr;
	logic signed [39:0] uv_thr;
	logic               wr_ok_ov;
	logic               wr_ok_uv;
	logic signed [39:0] vin_fx;
	logic               above_ov;
	logic               below_uv;
	logic               clear_cmd;
	logic               retry_code;

	// ------------------------------------------------------------------------
	// Threshold decoders
	// ------------------------------------------------------------------------
	// decode words
	ivfm_lin_dec #(.MAX_V(`IVFM_OV_WARN_MAX_V)) u_dec_wov (
		.word_in(cmd_wdata_in), .value_out(wr_val_ov), .in_range_out(wr_ok_ov));
	ivfm_lin_dec #(.MAX_V(`IVFM_UV_WARN_MAX_V)) u_dec_wuv (
		.word_in(cmd_wdata_in), .value_out(wr_val_uv), .in_range_out(wr_ok_uv));
	ivfm_lin_dec #(.MAX_V(`IVFM_OV_WARN_MAX_V)) u_dec_ov (
		.word_in(r_q.ov_warn), .value_out(ov_thr), .in_range_out());
	ivfm_lin_dec #(.MAX_V(`IVFM_UV_WARN_MAX_V)) u_dec_uv (
		.word_in(r_q.uv_warn), .value_out(uv_thr), .in_range_out());

	// Comparisons against the live thresholds
	assign vin_fx    = $signed({24'h0, vin_meas_in});
	assign above_ov  = vin_fx > ov_thr;
	assign below_uv  = vin_fx < uv_thr;
	assign clear_cmd = cmd_valid_in && cmd_write_in
		&& (cmd_code_in == `IVFM_CMD_CLEAR_FAULTS);
	assign retry_code = (r_q.ov_resp[`IVFM_MODE_HI:`IVFM_MODE_LO] == `IVFM_MODE_RETRY)
		&& (r_q.ov_resp[`IVFM_RETRY_HI:`IVFM_RETRY_LO] != 3'h0);

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.reject = 1'b0;

		// Command decode; byte registers read back zero-extended, warning thresholds as full 16-bit words
		if (cmd_valid_in) begin
			r_d.done = 1'b1;
			r_d.rdata = 16'h0000;
			case (cmd_code_in)
				`IVFM_CMD_CLEAR_FAULTS: begin
					r_d.reject = !cmd_write_in;
				end
				`IVFM_CMD_OV_RESP: begin
					if (cmd_write_in) begin
						r_d.ov_resp = cmd_wdata_in[7:0];
					end
					r_d.rdata = {8'h00, r_q.ov_resp};
				end
				`IVFM_CMD_OV_WARN: begin
					if (cmd_write_in && wr_ok_ov) begin
						r_d.ov_warn = cmd_wdata_in;
					end
					r_d.reject = cmd_write_in && !wr_ok_ov;
					r_d.rdata = r_q.ov_warn;
				end
				`IVFM_CMD_UV_WARN: begin
					if (cmd_write_in && wr_ok_uv) begin
						r_d.uv_warn = cmd_wdata_in;
					end
					r_d.reject = cmd_write_in && !wr_ok_uv;
					r_d.rdata = r_q.uv_warn;
				end
				`IVFM_CMD_STATUS_WORD: begin
					r_d.reject = cmd_write_in;
					r_d.rdata[`IVFM_SW_INPUT] = r_q.sw_input;
					r_d.rdata[`IVFM_SW_NOTA] = r_q.sw_nota;
				end
				`IVFM_CMD_STATUS_INPUT: begin
					r_d.reject = cmd_write_in;
					r_d.rdata = {8'h00, r_q.stat_in};
				end
				default: begin
					r_d.reject = 1'b1;
				end
			endcase
		end

		// clear first, so a same-cycle set below wins
		if (clear_cmd) begin
			r_d.stat_in = 8'h00;
			r_d.sw_nota = 1'b0;
			r_d.sw_input = 1'b0;
		end
		if (vin_ov_fault_in) begin
			r_d.stat_in[`IVFM_SI_OV_FAULT] = 1'b1;
		end
		if (above_ov) begin
			r_d.stat_in[`IVFM_SI_OV_WARN] = 1'b1;
		end
		if (below_uv) begin
			r_d.stat_in[`IVFM_SI_UV_WARN] = 1'b1;
		end
		if (vin_uv_fault_in) begin
			r_d.stat_in[`IVFM_SI_UV_FAULT] = 1'b1;
		end
		if (vin_ov_fault_in || above_ov || below_uv || vin_uv_fault_in) begin
			r_d.sw_nota = 1'b1;
			r_d.sw_input = 1'b1;
		end

		// undervoltage hold released above the warning level with retry, else by clear-faults
		if (vin_uv_fault_in) begin
			r_d.uv_hold = 1'b1;
		end else if (r_q.uv_hold && ((uv_retry_in && vin_fx > uv_thr)
			|| (!uv_retry_in && clear_cmd))) begin
			r_d.uv_hold = 1'b0;
		end

		// Retry timer: whole 35 ms units counted up to delay+1
		if (r_q.st == IVFM_ST_RETRY && !r_q.tmr_done) begin
			if (r_q.unit_cnt == UNIT_LAST) begin
				r_d.unit_cnt = '0;
				r_d.slot = r_q.slot + 3'h1;
				r_d.tmr_done = r_q.slot == r_q.ov_resp[`IVFM_DELAY_HI:`IVFM_DELAY_LO];
			end else begin
				r_d.unit_cnt = r_q.unit_cnt + `IVFM_UNIT_W'(1);
			end
		end

		// Sequencing; command-off and other faults force OFF except from LATCH or an idle fault latch below
		if (!enable_in || other_fault_in) begin
			r_d.st = (r_q.st == IVFM_ST_LATCH) ? IVFM_ST_LATCH : IVFM_ST_OFF;
		end else begin
			case (r_q.st)
				IVFM_ST_OFF: begin
					r_d.st = IVFM_ST_RUN;
				end
				IVFM_ST_RUN: begin
					if (vin_ov_fault_in) begin
						r_d.st = retry_code ? IVFM_ST_RETRY : IVFM_ST_LATCH;
						r_d.unit_cnt = '0;
						r_d.slot = 3'h0;
						r_d.tmr_done = 1'b0;
					end
				end
				IVFM_ST_LATCH: begin
					if (clear_cmd && !vin_ov_fault_in) begin
						r_d.st = IVFM_ST_OFF;
					end
				end
				IVFM_ST_RETRY: begin
					// wait for input below the warning level
					if (r_q.tmr_done && !above_ov && !vin_ov_fault_in) begin
						r_d.st = IVFM_ST_RUN;
					end
				end
				default: begin
					r_d.st = IVFM_ST_OFF;
				end
			endcase
		end
		// An overvoltage fault seen while idle still latches if not retrying
		if (r_q.st == IVFM_ST_OFF && vin_ov_fault_in && !retry_code) begin
			r_d.st = IVFM_ST_LATCH;
		end

		r_d.pwr = (r_d.st == IVFM_ST_RUN) && !r_d.uv_hold && !vin_ov_fault_in;
		// alert low while any status bit stands
		r_d.alert_n = !(|r_d.stat_in);
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!nrst_in) begin
			r_q <= '0;
			r_q.st <= IVFM_ST_OFF;
			r_q.ov_resp <= `IVFM_OV_RESP_RST;
			r_q.ov_warn <= `IVFM_OV_WARN_RST;
			r_q.uv_warn <= `IVFM_UV_WARN_RST;
			r_q.alert_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign cmd_rdata_out      = r_q.rdata;
	assign cmd_done_out       = r_q.done;
	assign cmd_reject_out     = r_q.reject;
	assign power_enable_out   = r_q.pwr;
	assign alert_output_n_out = r_q.alert_n;
	assign alert_oe_n_out     = r_q.alert_n;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	logic [39:0] retry_cyc;
	always_ff @(posedge mclk_in) begin
		if (!nrst_in || r_q.st != IVFM_ST_RETRY) begin
			retry_cyc <= 40'h0;
		end else begin
			retry_cyc <= retry_cyc + 40'h1;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	fault_alert_a: assert property (vin_ov_fault_in |=> !alert_output_n_out
		&& r_q.stat_in[`IVFM_SI_OV_FAULT]) else $error("fault did not alert");
	sticky_status_a: assert property ($fell(r_q.stat_in[`IVFM_SI_OV_FAULT])
		|-> $past(clear_cmd)) else $error("fault bit dropped without clear");
	latch_hold_a: assert property (r_q.st == IVFM_ST_LATCH && !clear_cmd
		|=> r_q.st == IVFM_ST_LATCH && !power_enable_out)
		else $error("latched fault released");
	bad_code_a: assert property (r_q.st == IVFM_ST_RUN && vin_ov_fault_in && enable_in
		&& !other_fault_in && !retry_code |=> r_q.st == IVFM_ST_LATCH)
		else $error("non-retry code did not latch");
	cmd_off_a: assert property (!enable_in && r_q.st == IVFM_ST_RETRY
		|=> r_q.st == IVFM_ST_OFF) else $error("retry kept after off");
	restart_low_a: assert property (r_q.st == IVFM_ST_RETRY && r_d.st == IVFM_ST_RUN
		|-> !above_ov) else $error("restart above warning");
	retry_time_a: assert property (r_q.st == IVFM_ST_RETRY && r_d.st == IVFM_ST_RUN
		|-> retry_cyc >= 40'(r_q.ov_resp[2:0] + 4'h1) * 40'(RETRY_UNIT_CYC))
		else $error("restart interval too short");
	ov_warn_a: assert property (above_ov |=> r_q.stat_in[`IVFM_SI_OV_WARN]
		&& r_q.sw_nota && r_q.sw_input) else $error("ov warning not flagged");
	uv_warn_a: assert property (below_uv |=> r_q.stat_in[`IVFM_SI_UV_WARN]
		&& r_q.sw_nota && r_q.sw_input) else $error("uv warning not flagged");
	span_reject_a: assert property (cmd_valid_in && cmd_write_in
		&& cmd_code_in == `IVFM_CMD_OV_WARN && !wr_ok_ov
		|=> cmd_reject_out && $stable(r_q.ov_warn)) else $error("bad ov write kept");
	uv_release_a: assert property ($fell(r_q.uv_hold) && $past(uv_retry_in)
		|-> $past(vin_fx) > $past(uv_thr)) else $error("uv hold left too early");

endmodule
`default_nettype wire
